// [include/tic_pkg.sv]
// shared constants and types of the timer input capture block
package tic_pkg;

	// =====================================================
	// register offsets
	localparam logic [7:0] OFS_CTL  = 8'h00;
	localparam logic [7:0] OFS_CMP  = 8'h04;
	localparam logic [7:0] OFS_INTS = 8'h08;
	localparam logic [7:0] OFS_CNT  = 8'h0C;
	localparam logic [7:0] OFS_CAP  = 8'h10;
	localparam logic [7:0] OFS_EXT  = 8'h14;
	localparam logic [7:0] OFS_EINT = 8'h18;

	// =====================================================
	// reset values
	localparam logic [31:0] CTL_RST  = 32'h0000_0005;
	localparam logic [31:0] ZERO_RST = 32'h0000_0000;

	// =====================================================
	// field positions
	localparam int CTL_CNTEN  = 30;
	localparam int CTL_SRCSEL = 19;
	localparam int EXT_EDGE_LO = 1;
	localparam int EXT_CAPON   = 3;
	localparam int EXT_FUNC    = 4;
	localparam int EXT_IEN     = 5;
	localparam int EXT_DBEN    = 6;
	localparam int EXT_TRGSEL  = 8;
	localparam int EINT_IRQF   = 0;
	localparam int EINT_EVTF   = 1;

	// =====================================================
	// widths, masks and counts
	localparam int CNT_W = 24;
	localparam int DEB_LEN = 3;
	localparam logic [31:0] CTL_MASK  = 32'hFF88_00FF;
	localparam logic [31:0] EXT_MASK  = 32'h0000_01FF;
	localparam logic [31:0] INTS_MASK = 32'h0000_0007;

	// =====================================================
	// edge codes and types
	typedef enum logic [1:0] {
		EDGE_FALL   = 2'h0,
		EDGE_RISE   = 2'h1,
		EDGE_EITHER = 2'h2,
		EDGE_RSVD   = 2'h3
	} tic_edge_type;

	typedef enum {
		TRG_IDLE,
		TRG_COUNT,
		TRG_DONE
	} tic_trg_type;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} tic_bus_type;

endpackage

// [core/tic_capture.sv]
// timer input capture core with its register port
// ==========================================================
// Overview of operation
// - trigger mode with capture enabled: start edge zeroes the counter, stop edge loads capture data
// - two-bit edge field picks falling, rising or either edge
// - first trigger edge zeroes counter and starts upward counting
// - second trigger edge sets capture flag, interrupt flag if enabled
// - debounce filter on capture input, switched by ext register bit six
// - free mode copies counter into capture data on chosen edge
// - reset mode zeroes counter on chosen edge instead of capturing
// - code 00 trigger: first falling starts, second falling stops
// - code 01 trigger: first rising starts, second rising stops
// - code 10 trigger: either edge starts, the opposite edge stops
// - control resets to 5, other registers to zero
// - counter and capture data are read only
// - capture data held while the interrupt flag stays set
// - interrupt flag set only on capture edge with interrupt enable
// - source bit picks capture pin or low frequency clock
// - counter and capture data are 24 bits wide
module tic_capture
	import tic_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire tic_bus_type bus_i,
	output logic [31:0]      rdata_o,
	input  wire logic        cap_pin_i,
	input  wire logic        lf_clk_i,
	output logic             cap_irq_o,
	output logic [23:0]      cnt_o
);

	// =====================================================
	// registers
	logic [31:0]          ctl_q;
	logic [23:0]          cmp_q;
	logic [2:0]           ints_q;
	logic [CNT_W-1:0]     cnt_q;
	logic [CNT_W-1:0]     cap_q;
	logic [8:0]           ext_q;
	logic [1:0]           eint_q;
	logic [31:0]          rdata_q;
	tic_trg_type          trg_q;
	logic                 start_rise_q;

	// =====================================================
	// synchroniser and debounce
	logic                 pin_s1_q;
	logic                 pin_s2_q;
	logic                 lf_s1_q;
	logic                 lf_s2_q;
	logic [DEB_LEN-1:0]   deb_q;
	logic                 filt_q;
	logic                 prev_q;
	logic                 src;
	logic                 rise;
	logic                 fall;
	logic                 exp_edge;
	tic_edge_type         edge_sel;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			lf_s1_q  <= 1'b0;
			lf_s2_q  <= 1'b0;
		end else begin
			pin_s1_q <= cap_pin_i;
			pin_s2_q <= pin_s1_q;
			lf_s1_q  <= lf_clk_i;
			lf_s2_q  <= lf_s1_q;
		end
	end

	assign src = ctl_q[CTL_SRCSEL] ? lf_s2_q : pin_s2_q;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			deb_q  <= '0;
			filt_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			deb_q  <= {deb_q[DEB_LEN-2:0], src};
			prev_q <= filt_q;
			if (!ext_q[EXT_DBEN]) begin
				filt_q <= src;
			end else if (deb_q == {DEB_LEN{src}}) begin
				filt_q <= src;
			end
		end
	end

	assign rise = filt_q & ~prev_q;
	assign fall = ~filt_q & prev_q;
	assign edge_sel = tic_edge_type'(ext_q[EXT_EDGE_LO +: 2]);

	always_comb begin
		unique case (edge_sel)
			EDGE_FALL:   exp_edge = fall;
			EDGE_RISE:   exp_edge = rise;
			EDGE_EITHER: exp_edge = rise | fall;
			EDGE_RSVD:   exp_edge = 1'b0;
		endcase
	end

	// =====================================================
	// event decode
	logic cap_on;
	logic trg_mode;
	logic free_evt;
	logic rst_evt;
	logic start_evt;
	logic stop_evt;
	logic stop_edge;
	logic cap_ld;
	logic cap_evt;
	logic ext_wr;
	logic eint_wr;

	assign ext_wr   = bus_i.wr && bus_i.addr == OFS_EXT;
	assign eint_wr  = bus_i.wr && bus_i.addr == OFS_EINT;
	assign cap_on   = ext_q[EXT_CAPON] && !ext_q[EXT_FUNC];
	assign trg_mode = cap_on && ext_q[EXT_TRGSEL];
	assign free_evt = cap_on && !ext_q[EXT_TRGSEL] && exp_edge;
	assign rst_evt  = ext_q[EXT_CAPON] && ext_q[EXT_FUNC] && !ext_q[EXT_TRGSEL] && exp_edge;
	assign start_evt = trg_mode && trg_q == TRG_IDLE && exp_edge;

	always_comb begin
		if (edge_sel == EDGE_EITHER) begin
			stop_edge = start_rise_q ? fall : rise;
		end else begin
			stop_edge = exp_edge;
		end
	end

	assign stop_evt = trg_mode && trg_q == TRG_COUNT && stop_edge;
	assign cap_ld   = (free_evt || stop_evt) && !eint_q[EINT_IRQF];
	assign cap_evt  = free_evt || rst_evt || stop_evt;

	// =====================================================
	// trigger sequencer
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			trg_q        <= TRG_IDLE;
			start_rise_q <= 1'b0;
		end else if (ext_wr || !trg_mode) begin
			trg_q <= TRG_IDLE;
		end else begin
			unique case (trg_q)
				TRG_IDLE: begin
					if (start_evt) begin
						trg_q        <= TRG_COUNT;
						start_rise_q <= rise;
					end
				end
				TRG_COUNT: begin
					if (stop_evt) begin
						trg_q <= TRG_DONE;
					end
				end
				TRG_DONE: begin
					trg_q <= TRG_DONE;
				end
			endcase
		end
	end

	// =====================================================
	// up counter
	logic cnt_run;

	assign cnt_run = ext_q[EXT_TRGSEL] && cap_on ? trg_q == TRG_COUNT : ctl_q[CTL_CNTEN];

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cnt_q <= '0;
		end else if (rst_evt || start_evt) begin
			cnt_q <= '0;
		end else if (cnt_run && !stop_evt) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// =====================================================
	// capture data and flags
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cap_q <= '0;
		end else if (cap_ld) begin
			cap_q <= cnt_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			eint_q <= '0;
		end else begin
			if (cap_evt) begin
				eint_q[EINT_EVTF] <= 1'b1;
			end else if (eint_wr && bus_i.wdata[EINT_EVTF]) begin
				eint_q[EINT_EVTF] <= 1'b0;
			end
			if (cap_evt && ext_q[EXT_IEN]) begin
				eint_q[EINT_IRQF] <= 1'b1;
			end else if (eint_wr && bus_i.wdata[EINT_IRQF]) begin
				eint_q[EINT_IRQF] <= 1'b0;
			end
		end
	end

	assign cap_irq_o = eint_q[EINT_IRQF] && ext_q[EXT_IEN];
	assign cnt_o     = cnt_q;

	// =====================================================
	// register port
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			ctl_q  <= CTL_RST;
			cmp_q  <= ZERO_RST[23:0];
			ints_q <= ZERO_RST[2:0];
			ext_q  <= ZERO_RST[8:0];
		end else if (bus_i.wr) begin
			case (bus_i.addr)
				OFS_CTL:  ctl_q  <= bus_i.wdata & CTL_MASK;
				OFS_CMP:  cmp_q  <= bus_i.wdata[23:0];
				OFS_INTS: ints_q <= ints_q & ~bus_i.wdata[2:0];
				OFS_EXT:  ext_q  <= bus_i.wdata[8:0];
				default:  ints_q <= ints_q;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rdata_q <= '0;
		end else if (bus_i.rd) begin
			case (bus_i.addr)
				OFS_CTL:  rdata_q <= ctl_q;
				OFS_CMP:  rdata_q <= {8'h00, cmp_q};
				OFS_INTS: rdata_q <= {29'h0, ints_q};
				OFS_CNT:  rdata_q <= {8'h00, cnt_q};
				OFS_CAP:  rdata_q <= {8'h00, cap_q};
				OFS_EXT:  rdata_q <= {23'h0, ext_q};
				OFS_EINT: rdata_q <= {30'h0, eint_q};
				default:  rdata_q <= '0;
			endcase
		end else begin
			rdata_q <= '0;
		end
	end

	assign rdata_o = rdata_q;

	// =====================================================
	// assertions
	AST_FREE_CAP: assert property (@(posedge clk_i) disable iff (!rstn_i)
		free_evt && !eint_q[EINT_IRQF] |=> cap_q == $past(cnt_q))
		else $error("free capture did not load counter");

	AST_CAP_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
		eint_q[EINT_IRQF] |=> $stable(cap_q))
		else $error("capture data changed while flag set");

	AST_EXT_RST: assert property (@(posedge clk_i) disable iff (!rstn_i)
		rst_evt |=> cnt_q == '0)
		else $error("reset edge did not zero counter");

	AST_TRG_START: assert property (@(posedge clk_i) disable iff (!rstn_i)
		start_evt && !ext_wr |=> trg_q == TRG_COUNT && cnt_q == '0)
		else $error("trigger start did not zero and run");

	AST_TRG_FLAG: assert property (@(posedge clk_i) disable iff (!rstn_i)
		stop_evt |=> eint_q[EINT_EVTF] && trg_q != TRG_COUNT)
		else $error("stop edge did not flag");

	AST_IRQ_EN: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(eint_q[EINT_IRQF]) |-> $past(ext_q[EXT_IEN]))
		else $error("interrupt flag set without enable");

	AST_RO: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!cap_ld |=> $stable(cap_q))
		else $error("capture data changed without capture");

	AST_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
		trg_q == TRG_DONE && trg_mode && !ext_wr |=> $stable(cnt_q))
		else $error("counter moved after stop edge");

	AST_RST_VAL: assert property (@(posedge clk_i)
		!rstn_i |=> ctl_q == CTL_RST && cnt_q == '0 && cap_q == '0)
		else $error("reset values wrong");

	AST_SYNC: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!ctl_q[CTL_SRCSEL] && !ext_q[EXT_DBEN] ##1 $changed(filt_q)
			|-> filt_q == $past(pin_s1_q, 2))
		else $error("edge not from synchronised pin");

	AST_DEB_FILT: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$past(ext_q[EXT_DBEN]) && $changed(filt_q) |-> $past(deb_q) == {DEB_LEN{filt_q}})
		else $error("debounce passed an unsettled level");

	AST_CNT_RUN: assert property (@(posedge clk_i) disable iff (!rstn_i)
		trg_mode && trg_q == TRG_COUNT && !stop_evt |=> cnt_q - $past(cnt_q) == 24'h00_0001)
		else $error("trigger counter did not count up");

	AST_STOP_LOAD: assert property (@(posedge clk_i) disable iff (!rstn_i)
		stop_evt && !eint_q[EINT_IRQF] |=> cap_q == $past(cnt_q))
		else $error("stop edge did not load capture data");

	AST_EITHER_STOP: assert property (@(posedge clk_i) disable iff (!rstn_i)
		trg_mode && trg_q == TRG_COUNT && edge_sel == EDGE_EITHER && !ext_wr
			&& (start_rise_q ? fall : rise) |=> trg_q == TRG_DONE)
		else $error("either-edge trigger missed the opposite stop edge");

	AST_RST_FLAG: assert property (@(posedge clk_i) disable iff (!rstn_i)
		rst_evt |=> eint_q[EINT_EVTF])
		else $error("reset edge did not set capture flag");

	AST_FREE_FLAG: assert property (@(posedge clk_i) disable iff (!rstn_i)
		free_evt |=> eint_q[EINT_EVTF])
		else $error("free capture edge did not set capture flag");

	AST_RSVD: assert property (@(posedge clk_i) disable iff (!rstn_i)
		edge_sel == EDGE_RSVD && !eint_q[EINT_EVTF] |=> !eint_q[EINT_EVTF])
		else $error("reserved edge code raised a flag");

	AST_RO_CNT: assert property (@(posedge clk_i) disable iff (!rstn_i)
		bus_i.wr && bus_i.addr == OFS_CNT && !cnt_run && !rst_evt && !start_evt
			|=> $stable(cnt_q))
		else $error("counter changed by a register write");

	AST_SRC_LF: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$past(ctl_q[CTL_SRCSEL]) && !$past(ext_q[EXT_DBEN]) |-> filt_q == $past(lf_s2_q))
		else $error("low frequency source not selected");

	AST_IRQ_SRC: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(eint_q[EINT_IRQF]) |-> $past(cap_evt))
		else $error("interrupt flag set without capture edge");

	COV_FREE: cover property (@(posedge clk_i) free_evt && cap_ld);
	COV_TRG:  cover property (@(posedge clk_i) start_evt ##[1:1000] stop_evt);
	COV_RST:  cover property (@(posedge clk_i) rst_evt);
	COV_DROP: cover property (@(posedge clk_i) free_evt && eint_q[EINT_IRQF]);
	COV_DEB:  cover property (@(posedge clk_i) ext_q[EXT_DBEN] && rise);

endmodule // tic_capture

// [verif/tic_pin_model.sv]
// model of the signal source on the capture pin and the low-frequency clock
module tic_pin_model (
	input  wire logic clk_i,
	output logic      cap_pin_o,
	output logic      lf_clk_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ====================================================
	// level changes, launched just after a rising edge
	initial begin
		cap_pin_o = 1'b0;
		lf_clk_o = 1'b0;
	end

	// holds of three cycles or more keep the toggle rate legal
	task automatic put(input logic src, input logic v, input int hold);
		@(posedge clk_i);
		if (src) begin
			lf_clk_o <= v;
		end else begin
			cap_pin_o <= v;
		end
		repeat (hold) @(posedge clk_i);
	endtask
endmodule // tic_pin_model

// [verif/test_timer_input_capture.sv]
// self-checking testbench of the timer input capture block
module test_timer_input_capture
	import tic_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i;
	logic        rstn_i;
	tic_bus_type bus_i;
	logic [31:0] rdata_o;
	logic        cap_pin_i;
	logic        lf_clk_i;
	logic        cap_irq_o;
	logic [23:0] cnt_o;
	logic [31:0] d;
	logic [31:0] e;
	int          fail_count;
	int          total_checks;

	tic_capture DUT (.clk_i(clk_i), .rstn_i(rstn_i), .bus_i(bus_i), .rdata_o(rdata_o),
		.cap_pin_i(cap_pin_i), .lf_clk_i(lf_clk_i), .cap_irq_o(cap_irq_o), .cnt_o(cnt_o));
	tic_pin_model PIN (.clk_i(clk_i), .cap_pin_o(cap_pin_i), .lf_clk_o(lf_clk_i));

	// ====================================================
	// clock, bus and compare helpers
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic ok(input string nm, input logic b);
		chk(nm, {31'h0, b}, 32'h0000_0001);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		bus_i <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk_i);
		bus_i.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_i);
		bus_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_i);
		bus_i.rd <= 1'b0;
		#1 v = rdata_o;
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ====================================================
	// scenarios
	task automatic t_regs;
		logic [7:0] ofs [7] = '{OFS_CTL, OFS_CMP, OFS_INTS, OFS_CNT, OFS_CAP, OFS_EXT, OFS_EINT};
		for (int i = 0; i < 7; i++) begin
			rd(ofs[i], d);
			chk("reset value", d, (i == 0) ? CTL_RST : ZERO_RST);
		end
		wr(OFS_CNT, 32'h0000_1234);
		wr(OFS_CAP, 32'h0000_5678);
		rd(OFS_CNT, d);
		chk("cnt ro", d, ZERO_RST);
		rd(OFS_CAP, d);
		chk("cap ro", d, ZERO_RST);
		rd(8'h1C, d);
		chk("unmapped", d, ZERO_RST);
		$display("test regs done");
	endtask

	task automatic t_free;
		wr(OFS_CTL, 32'h4000_0005);
		for (int c = 0; c < 4; c++) begin
			wr(OFS_EXT, 32'h0000_0008 | 32'(c << 1));
			wr(OFS_EINT, 32'h0000_0003);
			PIN.put(1'b0, 1'b1, 10);
			rd(OFS_EINT, d);
			chk("rise flag", d, {30'h0, c == 1 || c == 2, 1'b0});
			wr(OFS_EINT, 32'h0000_0003);
			PIN.put(1'b0, 1'b0, 10);
			rd(OFS_EINT, d);
			chk("fall flag", d, {30'h0, c == 0 || c == 2, 1'b0});
			rd(OFS_CAP, d);
			rd(OFS_CNT, e);
			ok("cap", d != 0 && d < e && d[31:24] == 8'h00);
		end
		wr(OFS_EXT, 32'h0000_001A);
		PIN.put(1'b0, 1'b1, 6);
		rd(OFS_CNT, d);
		ok("cnt zeroed", d < 16);
		PIN.put(1'b0, 1'b0, 10);
		$display("test free and reset done");
	endtask

	task automatic t_trig;
		int iv;
		for (int k = 0; k < 4; k++) begin
			iv = (k < 2) ? 50 : 25;
			PIN.put(1'b0, k == 3, 10);
			wr(OFS_EXT, 32'h0000_0128 | 32'(((k > 2) ? 2 : k) << 1));
			wr(OFS_EINT, 32'h0000_0003);
			repeat (4) PIN.put(1'b0, ~cap_pin_i, 24);
			rd(OFS_CNT, d);
			ok("interval", d >= iv - 3 && d <= iv + 3);
			chk("cnt out", {8'h00, cnt_o}, d);
			repeat (5) @(posedge clk_i);
			rd(OFS_CNT, e);
			chk("held", e, d);
			rd(OFS_CAP, e);
			chk("cap", e, d);
			rd(OFS_EINT, e);
			chk("flags", e, 32'h0000_0003);
			ok("irq", cap_irq_o);
			wr(OFS_EXT, 32'h0000_0108);
			wr(OFS_EINT, 32'h0000_0003);
		end
		$display("test trigger done");
	endtask

	task automatic t_hold;
		PIN.put(1'b0, 1'b0, 10);
		wr(OFS_EXT, 32'h0000_002A);
		wr(OFS_EINT, 32'h0000_0003);
		PIN.put(1'b0, 1'b1, 10);
		rd(OFS_CAP, d);
		ok("irq", cap_irq_o);
		PIN.put(1'b0, 1'b0, 10);
		PIN.put(1'b0, 1'b1, 10);
		rd(OFS_CAP, e);
		chk("cap kept", e, d);
		wr(OFS_EXT, 32'h0000_000A);
		wr(OFS_EINT, 32'h0000_0003);
		PIN.put(1'b0, 1'b0, 10);
		PIN.put(1'b0, 1'b1, 10);
		rd(OFS_EINT, d);
		chk("no irq flag", d, 32'h0000_0002);
		ok("irq low", !cap_irq_o);
		$display("test hold done");
	endtask

	task automatic t_deb_src;
		wr(OFS_EXT, 32'h0000_004A);
		PIN.put(1'b0, 1'b0, 10);
		wr(OFS_EINT, 32'h0000_0003);
		PIN.put(1'b0, 1'b1, 0);
		PIN.put(1'b0, 1'b0, 10);
		rd(OFS_EINT, d);
		chk("glitch", d, 32'h0000_0000);
		PIN.put(1'b0, 1'b1, 10);
		rd(OFS_EINT, d);
		chk("filtered", d, 32'h0000_0002);
		wr(OFS_CTL, 32'h4008_0005);
		wr(OFS_EXT, 32'h0000_000A);
		PIN.put(1'b0, 1'b0, 10);
		wr(OFS_EINT, 32'h0000_0003);
		PIN.put(1'b0, 1'b1, 10);
		rd(OFS_EINT, d);
		chk("pin ignored", d, 32'h0000_0000);
		PIN.put(1'b1, 1'b1, 10);
		rd(OFS_EINT, d);
		chk("lf edge", d, 32'h0000_0002);
		$display("test debounce and source done");
	endtask

	// ====================================================
	// main sequence and watchdog
	initial begin
		rstn_i = 1'b0;
		bus_i = '0;
		fail_count = 0;
		total_checks = 0;
		repeat (20) @(posedge clk_i);
		rstn_i <= 1'b1;
		t_regs;
		t_free;
		t_trig;
		t_hold;
		t_deb_src;
		tally_and_finish;
	end

	initial begin
		repeat (50000) @(posedge clk_i);
		fail_count++;
		tally_and_finish;
	end
endmodule // test_timer_input_capture
